// *** inc/dsw_pkg.sv ***
// Constants, types and state layout of the dual converter serial write port
package dsw_pkg;

    localparam int WORD_W = 16;
    localparam int CODE_W = 12;
    localparam int CNT_W = 5;
    localparam int FIFO_DEPTH = 32;

    // Word field positions
    localparam int SEL_HI_BIT = 15;
    localparam int SPEED_BIT = 14;
    localparam int PDOWN_BIT = 13;
    localparam int SEL_LO_BIT = 12;
    localparam int REF_HI_BIT = 1;
    localparam int REF_LO_BIT = 0;

    // Bit counter values
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
    localparam logic [CNT_W-1:0] CNT_LAST = 5'h0F;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;

    // Reset values
    localparam logic [CODE_W-1:0] CODE_RST = 12'h000;
    localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
    localparam logic CTL_BIT_RST = 1'h0;

    // Target select encodings {hi, lo}
    localparam logic [1:0] TGT_DACB_BUF = 2'h0;
    localparam logic [1:0] TGT_BUF = 2'h1;
    localparam logic [1:0] TGT_DACA_SYNC = 2'h2;
    localparam logic [1:0] TGT_CTRL = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_SHIFT = 3'h2,
        ST_WAIT = 3'h4
    } dsw_fsm_t;

    typedef struct packed {
        dsw_fsm_t fsm;
        logic sclk_d;
        logic cs_n_d;
        logic [WORD_W-1:0] sreg;
        logic [CNT_W-1:0] cnt;
        logic push;
        logic [WORD_W-1:0] push_word;
        logic [CODE_W-1:0] dac_a;
        logic [CODE_W-1:0] dac_b;
        logic [CODE_W-1:0] hold_buf;
        logic refsrc_sel_hi;
        logic refsrc_sel_lo;
        logic settle_speed_sel;
        logic power_down_ctl;
        logic upd;
        logic full;
    } dsw_core_st_t;

    // Target of a word: {high select, low select}
    function automatic logic [1:0] dsw_target(input logic [WORD_W-1:0] w);
        dsw_target = {w[SEL_HI_BIT], w[SEL_LO_BIT]};
    endfunction

endpackage

// *** rtl/dsw_top.sv ***
// Serial write port, word FIFO and latch control of a dual converter
// Functional notes
// - CS falling starts transfer; bits shift in MSB first on SCLK falls
// - After 16 bits or CS rise, shift register goes to selected target
// - Reset clears every latch to zero
// - Word is 16 bits: two select, speed and power-down bits on top, twelve payload bits
// - Bit 14 set picks fast settling, clear picks slow settling
// - Bit 13 set powers down, clear means normal operation
// - Selects 00 write payload to second converter and holding buffer
// - Selects 01 write holding buffer only; converters unchanged
// - Selects 10 load first converter, second from buffer, together
// - Selects 11 write the control register only
// - Converter or buffer target takes all twelve payload bits
// - Converter code is unsigned 12 bit, 000 to FFF
// - Latch update follows the rising SCLK after the sixteenth bit
// - Control write: low two payload bits pick reference source
`timescale 1ns/1ps

module dsw_fifo #(
    parameter int W = 16,
    parameter int D = 32
) (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW:0] wp;
        logic [AW:0] rp;
    } dsw_fifo_st_t;

    dsw_fifo_st_t st_reg;
    dsw_fifo_st_t st_next;
    logic full;
    logic empty;

    always_comb begin
        empty = (st_reg.wp == st_reg.rp);
        full = (st_reg.wp[AW-1:0] == st_reg.rp[AW-1:0]) &&
               (st_reg.wp[AW] != st_reg.rp[AW]);
        in_ready = !full;
        out_valid = !empty;
        out_data = st_reg.mem[st_reg.rp[AW-1:0]];
        st_next = st_reg;
        if (in_valid && !full) begin
            st_next.mem[st_reg.wp[AW-1:0]] = in_data;
            st_next.wp = st_reg.wp + 1'b1;
        end
        if (out_ready && !empty) begin
            st_next.rp = st_reg.rp + 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_reg <= '0;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    // Checks
    no_overrun_a: assert property (
        @(posedge CORE_CLK) disable iff (!RST_N)
        ce && full |=> st_reg.wp == $past(st_reg.wp))
        else $error("word FIFO written while full");

    no_underrun_a: assert property (
        @(posedge CORE_CLK) disable iff (!RST_N)
        ce && empty |=> st_reg.rp == $past(st_reg.rp))
        else $error("word FIFO read while empty");
endmodule // dsw_fifo

module dsw_top
    import dsw_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic SCLK,
    input wire logic DIN,
    input wire logic CS_N,
    input wire logic LATCH_HOLD,
    output logic [CODE_W-1:0] DAC_A_CODE,
    output logic [CODE_W-1:0] DAC_B_CODE,
    output logic [CODE_W-1:0] HOLD_BUF_CODE,
    output logic REFSRC_SEL_HI,
    output logic REFSRC_SEL_LO,
    output logic SETTLE_SPEED_SEL,
    output logic POWER_DOWN_CTL,
    output logic UPDATE_PULSE,
    output logic FIFO_FULL
);
    dsw_core_st_t st_reg;
    dsw_core_st_t st_next;

    logic sclk_fall;
    logic sclk_rise;
    logic cs_fall;
    logic cs_rise;
    logic f_in_ready;
    logic f_out_valid;
    logic f_out_ready;
    logic [WORD_W-1:0] f_out_data;
    logic apply_fire;
    logic [1:0] tgt;
    logic [CODE_W-1:0] payload;

    dsw_fifo #(
        .W(WORD_W),
        .D(FIFO_DEPTH)
    ) u_fifo (
        .CORE_CLK(CORE_CLK),
        .RST_N(RST_N),
        .ce(CE),
        .in_valid(st_reg.push),
        .in_ready(f_in_ready),
        .in_data(st_reg.push_word),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out_data)
    );

    always_comb begin
        sclk_fall = st_reg.sclk_d && !SCLK;
        sclk_rise = !st_reg.sclk_d && SCLK;
        cs_fall = st_reg.cs_n_d && !CS_N;
        cs_rise = !st_reg.cs_n_d && CS_N;
        f_out_ready = !LATCH_HOLD;
        apply_fire = f_out_valid && f_out_ready;
        tgt = dsw_target(f_out_data);
        payload = f_out_data[CODE_W-1:0];
        st_next = st_reg;
        st_next.sclk_d = SCLK;
        st_next.cs_n_d = CS_N;
        st_next.upd = 1'b0;
        st_next.full = !f_in_ready;
        // Word waits for the FIFO; stalls the push stage while full
        if (st_reg.push && f_in_ready) begin
            st_next.push = 1'b0;
        end
        // Serial front end
        case (st_reg.fsm)
            ST_IDLE: begin
                if (cs_fall) begin
                    st_next.cnt = CNT_ZERO;
                    st_next.fsm = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (cs_rise) begin
                    if (st_reg.cnt != CNT_ZERO) begin
                        st_next.push = 1'b1;
                        st_next.push_word = st_reg.sreg;
                    end
                    st_next.fsm = ST_IDLE;
                end else if (sclk_fall) begin
                    st_next.sreg = {st_reg.sreg[WORD_W-2:0], DIN};
                    st_next.cnt = st_reg.cnt + CNT_ONE;
                    if (st_reg.cnt == CNT_LAST) begin
                        st_next.fsm = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                if (sclk_rise || cs_rise) begin
                    st_next.push = 1'b1;
                    st_next.push_word = st_reg.sreg;
                    st_next.fsm = ST_IDLE;
                end
            end
            default: begin
                st_next.fsm = ST_IDLE;
            end
        endcase
        // Latch update stage
        if (apply_fire) begin
            st_next.upd = 1'b1;
            st_next.settle_speed_sel = f_out_data[SPEED_BIT];
            st_next.power_down_ctl = f_out_data[PDOWN_BIT];
            case (tgt)
                TGT_DACB_BUF: begin
                    st_next.dac_b = payload;
                    st_next.hold_buf = payload;
                end
                TGT_BUF: begin
                    st_next.hold_buf = payload;
                end
                TGT_DACA_SYNC: begin
                    st_next.dac_a = payload;
                    st_next.dac_b = st_reg.hold_buf;
                end
                TGT_CTRL: begin
                    st_next.refsrc_sel_hi = payload[REF_HI_BIT];
                    st_next.refsrc_sel_lo = payload[REF_LO_BIT];
                end
                default: begin
                    st_next.upd = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_reg.fsm <= ST_IDLE;
            st_reg.sclk_d <= 1'b0;
            st_reg.cs_n_d <= 1'b1;
            st_reg.sreg <= WORD_RST;
            st_reg.cnt <= CNT_ZERO;
            st_reg.push <= 1'b0;
            st_reg.push_word <= WORD_RST;
            st_reg.dac_a <= CODE_RST;
            st_reg.dac_b <= CODE_RST;
            st_reg.hold_buf <= CODE_RST;
            st_reg.refsrc_sel_hi <= CTL_BIT_RST;
            st_reg.refsrc_sel_lo <= CTL_BIT_RST;
            st_reg.settle_speed_sel <= CTL_BIT_RST;
            st_reg.power_down_ctl <= CTL_BIT_RST;
            st_reg.upd <= 1'b0;
            st_reg.full <= 1'b0;
        end else if (CE) begin
            st_reg <= st_next;
        end
    end

    assign DAC_A_CODE = st_reg.dac_a;
    assign DAC_B_CODE = st_reg.dac_b;
    assign HOLD_BUF_CODE = st_reg.hold_buf;
    assign REFSRC_SEL_HI = st_reg.refsrc_sel_hi;
    assign REFSRC_SEL_LO = st_reg.refsrc_sel_lo;
    assign SETTLE_SPEED_SEL = st_reg.settle_speed_sel;
    assign POWER_DOWN_CTL = st_reg.power_down_ctl;
    assign UPDATE_PULSE = st_reg.upd;
    assign FIFO_FULL = st_reg.full;

    // Checks
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_N);

    cnt_clear_a: assert property (
        CE && st_reg.fsm == ST_IDLE && cs_fall
        |=> st_reg.cnt == CNT_ZERO && st_reg.fsm == ST_SHIFT)
        else $error("bit counter not cleared on chip select fall");

    idle_ignore_a: assert property (
        st_reg.fsm == ST_IDLE && !cs_fall |=> $stable(st_reg.sreg))
        else $error("bit shifted while no transfer open");

    shift_msb_a: assert property (
        CE && st_reg.fsm == ST_SHIFT && !cs_rise && sclk_fall
        |=> st_reg.sreg[0] == $past(DIN)
            && st_reg.sreg[WORD_W-1:1] == $past(st_reg.sreg[WORD_W-2:0]))
        else $error("serial bit not shifted in at the bottom");

    word_done_a: assert property (
        CE && st_reg.fsm == ST_WAIT && sclk_rise
        |=> st_reg.push && st_reg.push_word == $past(st_reg.sreg))
        else $error("full word not pushed on following rising clock");

    cs_rise_a: assert property (
        CE && st_reg.fsm == ST_SHIFT && cs_rise && st_reg.cnt != CNT_ZERO
        |=> st_reg.push && st_reg.fsm == ST_IDLE)
        else $error("chip select rise did not transfer the word");

    dacb_buf_a: assert property (
        CE && apply_fire && tgt == TGT_DACB_BUF
        |=> DAC_B_CODE == $past(payload) && HOLD_BUF_CODE == $past(payload)
            && $stable(DAC_A_CODE))
        else $error("select 00 did not load second converter and buffer");

    buf_only_a: assert property (
        CE && apply_fire && tgt == TGT_BUF
        |=> HOLD_BUF_CODE == $past(payload) && $stable(DAC_A_CODE)
            && $stable(DAC_B_CODE))
        else $error("select 01 touched a converter");

    daca_sync_a: assert property (
        CE && apply_fire && tgt == TGT_DACA_SYNC
        |=> DAC_A_CODE == $past(payload)
            && DAC_B_CODE == $past(st_reg.hold_buf))
        else $error("select 10 did not update both converters");

    ctrl_write_a: assert property (
        CE && apply_fire && tgt == TGT_CTRL
        |=> {REFSRC_SEL_HI, REFSRC_SEL_LO} == $past(payload[1:0])
            && $stable(DAC_A_CODE) && $stable(DAC_B_CODE)
            && $stable(HOLD_BUF_CODE))
        else $error("control write went to the wrong latch");

    speed_pd_a: assert property (
        CE && apply_fire
        |=> SETTLE_SPEED_SEL == $past(f_out_data[SPEED_BIT])
            && POWER_DOWN_CTL == $past(f_out_data[PDOWN_BIT])
            && UPDATE_PULSE)
        else $error("speed or power bit not applied with the update");

    no_word_hold_a: assert property (
        CE && !apply_fire
        |=> !UPDATE_PULSE && $stable(DAC_A_CODE) && $stable(DAC_B_CODE)
            && $stable(HOLD_BUF_CODE))
        else $error("latch changed without a word from the FIFO");

    wait_ignore_a: assert property (
        CE && st_reg.fsm == ST_WAIT && !sclk_rise && !cs_rise
        |=> st_reg.fsm == ST_WAIT && $stable(st_reg.sreg))
        else $error("clock edge after the sixteenth bit was not ignored");

    last_bit_a: assert property (
        CE && st_reg.fsm == ST_SHIFT && !cs_rise && sclk_fall
            && st_reg.cnt == CNT_LAST
        |=> st_reg.fsm == ST_WAIT && st_reg.cnt == CNT_LAST + CNT_ONE)
        else $error("sixteenth bit did not close the shift phase");

    push_hold_a: assert property (
        CE && st_reg.push && !f_in_ready && !sclk_rise && !cs_rise
        |=> st_reg.push && $stable(st_reg.push_word))
        else $error("pending word dropped while the FIFO was full");

    fsm_onehot_a: assert property (
        $onehot(st_reg.fsm))
        else $error("serial state register left its one-hot codes");

    cov_sync_c: cover property (
        CE && apply_fire && tgt == TGT_DACA_SYNC);
    cov_short_c: cover property (
        CE && st_reg.fsm == ST_SHIFT && cs_rise && st_reg.cnt != CNT_ZERO);
    cov_ctrl_c: cover property (CE && apply_fire && tgt == TGT_CTRL);
    cov_full_c: cover property (FIFO_FULL && st_reg.push);
    cov_drain_c: cover property (CE && apply_fire ##1 CE && apply_fire);

endmodule // dsw_top

// *** dv/dsw_host.sv ***
// Host serial controller model driving the three-wire write port
`timescale 1ns/1ps
module dsw_host (
    input wire logic CORE_CLK,
    output logic SCLK,
    output logic DIN,
    output logic CS_N
);
    initial begin
        SCLK = 1'b0;
        DIN = 1'b0;
        CS_N = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge CORE_CLK);
    endtask

    // Sends the top nbits of w; a full word ends with the closing rise
    task automatic send(input logic [15:0] w, input int nbits, input int hp,
                        input int gap);
        CS_N <= 1'b0;
        tick(hp);
        for (int i = 0; i < nbits; i++) begin
            SCLK <= 1'b1;
            DIN <= w[15-i];
            tick(hp);
            SCLK <= 1'b0;
            tick(hp);
            if (i == 7) tick(gap);
        end
        if (nbits == 16) begin
            SCLK <= 1'b1;
            tick(hp);
            SCLK <= 1'b0;
            tick(hp);
        end
        CS_N <= 1'b1;
        DIN <= ~DIN;
        tick(3);
    endtask

    // Clock pulses with the port deselected
    task automatic wiggle(input int n);
        repeat (n) begin
            SCLK <= ~SCLK;
            DIN <= ~DIN;
            tick(2);
        end
    endtask
endmodule // dsw_host

// *** dv/dual_dac_serial_write_port_test.sv ***
// Self-checking bench of the serial write port
`timescale 1ns/1ps
module dual_dac_serial_write_port_test import dsw_pkg::*;;
    logic core_clk;
    logic rst_n;
    logic ce;
    logic latch_hold;
    wire sclk;
    wire din;
    wire cs_n;
    logic [CODE_W-1:0] dac_a;
    logic [CODE_W-1:0] dac_b;
    logic [CODE_W-1:0] hold_buf;
    logic ref_hi;
    logic ref_lo;
    logic speed;
    logic pdown;
    logic upd;
    logic full;
    int err_total = 0;
    int samples_checked = 0;
    int pulses = 0;
    int cycles = 0;
    wire [39:0] outs = {dac_a, dac_b, hold_buf, ref_hi, ref_lo, speed, pdown};
    logic [15:0] row_w [9] = '{16'hD002, 16'h0ABC, 16'h1123, 16'h8FFF,
        16'h7000, 16'h9001, 16'hB003, 16'h9000, 16'h0000};
    logic [39:0] row_e [9] = '{40'h000000000A, 40'h000ABCABC8,
        40'h000ABC1238, 40'hFFF1231238, 40'hFFF123000B, 40'hFFF1230004,
        40'hFFF123000D, 40'hFFF1230000, 40'hFFF0000000};

    dsw_host u_dsw_host (.CORE_CLK(core_clk), .SCLK(sclk), .DIN(din),
        .CS_N(cs_n));
    dsw_top u_dsw_top (.CORE_CLK(core_clk), .RST_N(rst_n), .CE(ce),
        .SCLK(sclk), .DIN(din), .CS_N(cs_n), .LATCH_HOLD(latch_hold),
        .DAC_A_CODE(dac_a), .DAC_B_CODE(dac_b), .HOLD_BUF_CODE(hold_buf),
        .REFSRC_SEL_HI(ref_hi), .REFSRC_SEL_LO(ref_lo),
        .SETTLE_SPEED_SEL(speed), .POWER_DOWN_CTL(pdown),
        .UPDATE_PULSE(upd), .FIFO_FULL(full));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(negedge core_clk) begin
        cycles++;
        if (upd === 1'b1) pulses++;
        if (cycles == 20000) begin
            err_total++;
            report_and_stop();
        end
    end

    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        if (err_total == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        latch_hold = 1'b0;
        wait_clk(3);
        check(outs, 40'h0);
        check({38'h0, upd, full}, 40'h0);
        rst_n <= 1'b1;
        wait_clk(2);
        for (int i = 0; i < 9; i++) begin
            u_dsw_host.send(row_w[i], 16, 2 + i % 4, (i % 2) * 5);
            wait_clk(8);
            check(outs, row_e[i]);
        end
        check(40'(pulses), 40'd9);
        u_dsw_host.send(16'h5A50, 12, 2, 0);
        wait_clk(8);
        check(outs, 40'hFFF5A55A50);
        u_dsw_host.wiggle(10);
        wait_clk(8);
        check({outs, 8'(pulses)}, {40'hFFF5A55A50, 8'd10});
        latch_hold <= 1'b1;
        for (int i = 0; i < 33; i++) begin
            u_dsw_host.send(16'h1000 | 16'(i), 16, 2, 0);
        end
        wait_clk(4);
        check({39'(pulses), full}, {39'd10, 1'b1});
        latch_hold <= 1'b0;
        wait_clk(40);
        check({39'(pulses), full}, {39'd43, 1'b0});
        check(outs, 40'hFFF5A50200);
        ce <= 1'b0;
        u_dsw_host.send(16'h8ABC, 16, 2, 0);
        ce <= 1'b1;
        wait_clk(8);
        check({outs, 8'(pulses)}, {40'hFFF5A50200, 8'd43});
        rst_n <= 1'b0;
        wait_clk(2);
        check(outs, 40'h0);
        check({38'h0, upd, full}, 40'h0);
        rst_n <= 1'b1;
        wait_clk(2);
        u_dsw_host.send(16'h8123, 16, 3, 0);
        wait_clk(8);
        check(outs, 40'h1230000000);
        report_and_stop();
    end
endmodule // dual_dac_serial_write_port_test
